// File: inc/flic_pkg.sv
// shared constants for the four level interrupt controller
package flic_pkg;
    localparam int NUM_SRC = 14;
    localparam int GRP_CNT = 7;
    localparam int IDX_W = 4;
    localparam int LVL_W = 2;
    localparam int NUM_LVL = 4;
    localparam logic [LVL_W-1:0] LVL_TOP = 2'h3;
    localparam int GATE_BIT = 7;
    // source indices, also the same-level polling rank (lowest wins)
    localparam int SRC_EXT0 = 0;
    localparam int SRC_TMR0 = 1;
    localparam int SRC_EXT1 = 2;
    localparam int SRC_TMR1 = 3;
    localparam int SRC_SERBOTH = 4;
    localparam int SRC_BROWN = 5;
    localparam int SRC_KEYB = 6;
    localparam int SRC_CMP = 7;
    localparam int SRC_WDRTC = 8;
    localparam int SRC_I2C = 9;
    localparam int SRC_SPI = 10;
    localparam int SRC_ADC = 11;
    localparam int SRC_SERRX = 12;
    localparam int SRC_SERTX = 13;
    localparam logic [1:0] EXT_RST = 2'h0;
    localparam logic [1:0] PIN_RST = 2'h3;
    localparam logic [NUM_LVL-1:0] SVC_RST = 4'h0;
    localparam logic [IDX_W-1:0] IDX_RST = 4'h0;
    localparam logic [LVL_W-1:0] LVL_RST = 2'h0;
    typedef enum logic [1:0] {
        ST_WAIT = 2'b01,
        ST_PRESENT = 2'b10
    } flic_state_t;
endpackage

// File: rtl/flic_core.sv
// four level interrupt controller: enables, priority, nesting, external inputs, wake
`timescale 1ns/1ns
`default_nettype none

// Function
// - four priority levels, any source any level
// - thirteen sources with two external inputs
// - thirteen sources: one external input plus SPI
// - per-source enable bit blocks its request
// - cleared global gate blocks every request
// - level from low/high priority register pairs
// - preempt only by strictly higher level
// - top-level routine is never preempted
// - higher pending level wins at boundary
// - polling order breaks same-level ties only
// - per-input edge or level type select
// - high then low sample sets request flag
// - enabled external interrupt wakes power-down, idle
// - any enabled request exits idle
module flic_core
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic spiVariant,
    input wire logic [7:0] irqEnableRegA,
    input wire logic [6:0] irqEnableRegB,
    input wire logic [6:0] prioLowRegA,
    input wire logic [6:0] prioHighRegA,
    input wire logic [6:0] prioLowRegB,
    input wire logic [6:0] prioHighRegB,
    input wire logic extIn0TypeSel,
    input wire logic extIn1TypeSel,
    input wire logic [1:0] extIrqPin,
    input wire logic [13:0] periphReq,
    input wire logic instrBoundary,
    input wire logic vectorAck,
    input wire logic serviceReturn,
    output logic irqReq,
    output logic [3:0] irqIndex,
    output logic [1:0] irqLevel,
    output logic [1:0] extRequestFlag,
    output logic [3:0] inService,
    output logic wakeIdle,
    output logic wakePowerDown
);
    localparam int N = flic_pkg::NUM_SRC;

    // ----------------------------------------------------------------
    // external inputs
    // ----------------------------------------------------------------
    logic [1:0] pinNow_q;
    logic [1:0] pinPrev_q;
    logic [1:0] edgeFlag_q;
    logic [1:0] typeSel;
    logic [1:0] fallSeen;
    logic [1:0] extReq;
    logic [1:0] extClr;
    logic [1:0] extPresent;

    assign typeSel = {extIn1TypeSel, extIn0TypeSel};
    assign fallSeen = pinPrev_q & ~pinNow_q;

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pinNow_q <= flic_pkg::PIN_RST;
            pinPrev_q <= flic_pkg::PIN_RST;
        end
        else
        begin
            pinNow_q <= extIrqPin;
            pinPrev_q <= pinNow_q;
        end
    end

    // ----------------------------------------------------------------
    // per-source pending, enable and level
    // ----------------------------------------------------------------
    logic [N-1:0] srcEnable;
    logic [N-1:0] srcPresent;
    logic [N-1:0] rawReq;
    logic [N-1:0] pending;
    logic [flic_pkg::LVL_W-1:0] srcLevel [N];
    logic globalGate;

    assign globalGate = irqEnableRegA[flic_pkg::GATE_BIT];
    assign extPresent = {~spiVariant, 1'b1};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_ext
            localparam int SI = (gi == 0) ? flic_pkg::SRC_EXT0 : flic_pkg::SRC_EXT1;
            assign extClr[gi] = vectorAck && (irqIndex == SI[flic_pkg::IDX_W-1:0]);
            // edge flag: a new falling edge wins over the vector clear
            always_ff @(posedge core_clk or negedge reset_n)
            begin
                if (!reset_n)
                    edgeFlag_q[gi] <= flic_pkg::EXT_RST[gi];
                else if (!typeSel[gi])
                    edgeFlag_q[gi] <= 1'b0;
                else if (fallSeen[gi])
                    edgeFlag_q[gi] <= 1'b1;
                else if (extClr[gi])
                    edgeFlag_q[gi] <= 1'b0;
            end
            assign extReq[gi] = extPresent[gi] && (typeSel[gi] ? edgeFlag_q[gi] : ~pinNow_q[gi]);
        end
        for (gi = 0; gi < N; gi++)
        begin : g_src
            if (gi < flic_pkg::GRP_CNT)
            begin : g_a
                assign srcEnable[gi] = irqEnableRegA[gi];
                assign srcLevel[gi] = {prioHighRegA[gi], prioLowRegA[gi]};
            end
            else
            begin : g_b
                assign srcEnable[gi] = irqEnableRegB[gi-flic_pkg::GRP_CNT];
                assign srcLevel[gi] = {prioHighRegB[gi-flic_pkg::GRP_CNT],
                    prioLowRegB[gi-flic_pkg::GRP_CNT]};
            end
            if (gi == flic_pkg::SRC_EXT0)
            begin : g_e0
                assign rawReq[gi] = extReq[0];
                assign srcPresent[gi] = 1'b1;
            end
            else if (gi == flic_pkg::SRC_EXT1)
            begin : g_e1
                assign rawReq[gi] = extReq[1];
                assign srcPresent[gi] = ~spiVariant;
            end
            else if (gi == flic_pkg::SRC_SPI)
            begin : g_spi
                assign rawReq[gi] = periphReq[gi];
                assign srcPresent[gi] = spiVariant;
            end
            else
            begin : g_per
                assign rawReq[gi] = periphReq[gi];
                assign srcPresent[gi] = 1'b1;
            end
            assign pending[gi] = rawReq[gi] && srcEnable[gi] && srcPresent[gi] && globalGate;
        end
    endgenerate

    assign extRequestFlag = edgeFlag_q;

    // ----------------------------------------------------------------
    // arbitration
    // ----------------------------------------------------------------
    logic bestValid;
    logic [flic_pkg::IDX_W-1:0] bestIdx;
    logic [flic_pkg::LVL_W-1:0] bestLvl;
    logic [flic_pkg::NUM_LVL-1:0] svc_q;
    logic svcAny;
    logic [flic_pkg::LVL_W-1:0] svcLvl;
    logic mayPreempt;

    always_comb
    begin
        bestValid = 1'b0;
        bestIdx = flic_pkg::IDX_RST;
        bestLvl = flic_pkg::LVL_RST;
        // descending scan, >= keeps the lowest index among equals
        for (int i = N - 1; i >= 0; i--)
        begin
            if (pending[i] && (!bestValid || srcLevel[i] >= bestLvl))
            begin
                bestValid = 1'b1;
                bestIdx = i[flic_pkg::IDX_W-1:0];
                bestLvl = srcLevel[i];
            end
        end
    end

    always_comb
    begin
        svcAny = 1'b0;
        svcLvl = flic_pkg::LVL_RST;
        for (int l = 0; l < flic_pkg::NUM_LVL; l++)
        begin
            if (svc_q[l])
            begin
                svcAny = 1'b1;
                svcLvl = l[flic_pkg::LVL_W-1:0];
            end
        end
    end

    assign mayPreempt = bestValid && (!svcAny || bestLvl > svcLvl);

    // ----------------------------------------------------------------
    // presentation to the core
    // ----------------------------------------------------------------
    flic_pkg::flic_state_t state_q;

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            state_q <= flic_pkg::ST_WAIT;
        else
        begin
            unique case (state_q)
                flic_pkg::ST_WAIT:
                    if (instrBoundary && mayPreempt)
                        state_q <= flic_pkg::ST_PRESENT;
                flic_pkg::ST_PRESENT:
                    if (vectorAck)
                        state_q <= flic_pkg::ST_WAIT;
                default:
                    state_q <= flic_pkg::ST_WAIT;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irqIndex <= flic_pkg::IDX_RST;
            irqLevel <= flic_pkg::LVL_RST;
        end
        else if (state_q == flic_pkg::ST_WAIT && instrBoundary && mayPreempt)
        begin
            irqIndex <= bestIdx;
            irqLevel <= bestLvl;
        end
    end

    assign irqReq = (state_q == flic_pkg::ST_PRESENT);

    // in-service levels: ack marks the level, return clears the top one
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            svc_q <= flic_pkg::SVC_RST;
        else
        begin
            for (int l = 0; l < flic_pkg::NUM_LVL; l++)
            begin
                if (irqReq && vectorAck && irqLevel == l[flic_pkg::LVL_W-1:0])
                    svc_q[l] <= 1'b1;
                else if (serviceReturn && svcAny && svcLvl == l[flic_pkg::LVL_W-1:0])
                    svc_q[l] <= 1'b0;
            end
        end
    end

    assign inService = svc_q;

    // ----------------------------------------------------------------
    // wake-up
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wakeIdle <= 1'b0;
            wakePowerDown <= 1'b0;
        end
        else
        begin
            wakeIdle <= |pending;
            wakePowerDown <= pending[flic_pkg::SRC_EXT0] || pending[flic_pkg::SRC_EXT1];
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_EDGE_SETS: assert property (@(posedge core_clk) disable iff (!reset_n)
        (typeSel[0] && pinPrev_q[0] && !pinNow_q[0]) |=> edgeFlag_q[0])
        else $error("falling edge did not set flag");
    AST_LEVEL_FOLLOWS: assert property (@(posedge core_clk) disable iff (!reset_n)
        !typeSel[0] |-> (extReq[0] == !pinNow_q[0]))
        else $error("level request not following pin");
    AST_GATE_BLOCKS: assert property (@(posedge core_clk) disable iff (!reset_n)
        !globalGate |-> (pending == '0) && !mayPreempt)
        else $error("request passed closed global gate");
    AST_ENABLE_BLOCKS: assert property (@(posedge core_clk) disable iff (!reset_n)
        ((pending & ~srcEnable) == '0))
        else $error("disabled source pending");
    AST_TOP_NO_PREEMPT: assert property (@(posedge core_clk) disable iff (!reset_n)
        svc_q[3] |-> !mayPreempt)
        else $error("top level routine preempted");
    AST_STRICT_HIGHER: assert property (@(posedge core_clk) disable iff (!reset_n)
        (state_q == flic_pkg::ST_WAIT && instrBoundary && svcAny) ##1 irqReq |-> irqLevel > $past(svcLvl))
        else $error("preempt by equal or lower level");
    AST_WINNER_LEVEL: assert property (@(posedge core_clk) disable iff (!reset_n)
        bestValid |-> (srcLevel[bestIdx] == bestLvl) && pending[bestIdx])
        else $error("winner level mismatch");
    AST_TIE_LOWEST: assert property (@(posedge core_clk) disable iff (!reset_n)
        (bestValid && bestIdx != flic_pkg::IDX_RST) |-> !(pending[0] && srcLevel[0] >= bestLvl))
        else $error("lower index same level lost");
    AST_SPI_VARIANT: assert property (@(posedge core_clk) disable iff (!reset_n)
        spiVariant |-> !pending[flic_pkg::SRC_EXT1])
        else $error("second external input active in spi variant");
    AST_WAKE_IDLE: assert property (@(posedge core_clk) disable iff (!reset_n)
        (|pending) |=> wakeIdle)
        else $error("idle wake missed");
endmodule

`default_nettype wire

// File: bench/flic_cpu_model.sv
// processor core model: instruction boundaries, vector acknowledge, service return
`timescale 1ns/1ns
`default_nettype none
module flic_cpu_model
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic irqReq,
    input wire logic [3:0] irqIndex,
    input wire logic [1:0] irqLevel,
    input wire logic [3:0] ackDelay,
    input wire logic boundaryEn,
    input wire logic retReq,
    output logic instrBoundary,
    output var logic vectorAck,
    output logic serviceReturn,
    output var logic [3:0] takenIndex,
    output var logic [1:0] takenLevel,
    output var logic [3:0] takenCount
);
    logic [3:0] waitCnt;
    assign instrBoundary = boundaryEn;
    assign serviceReturn = retReq;
    // ----------------------------------------
    // take the vector a set number of cycles after it appears
    // ----------------------------------------
    initial
    begin
        vectorAck = 1'b0;
        waitCnt = 4'h0;
        takenCount = 4'h0;
        takenIndex = 4'h0;
        takenLevel = 2'h0;
        forever
        begin
            @(posedge core_clk);
            if (vectorAck === 1'b1)
            begin
                takenIndex = irqIndex;
                takenLevel = irqLevel;
                takenCount = takenCount + 4'h1;
            end
            #1;
            if (vectorAck === 1'b1 || irqReq !== 1'b1 || reset_n !== 1'b1)
            begin
                vectorAck = 1'b0;
                waitCnt = 4'h0;
            end
            else if (waitCnt == ackDelay)
                vectorAck = 1'b1;
            else
                waitCnt = waitCnt + 4'h1;
        end
    end
endmodule
`default_nettype wire

// File: bench/flic_core_test.sv
// self-checking testbench of the interrupt controller core
`timescale 1ns/1ns
`default_nettype none
module flic_core_test;
    logic core_clk, reset_n, spiVariant, extIn0TypeSel, extIn1TypeSel, boundaryEn, retReq;
    logic [7:0] irqEnableRegA;
    logic [6:0] irqEnableRegB, prioLowRegA, prioHighRegA, prioLowRegB, prioHighRegB;
    logic [1:0] extIrqPin, irqLevel, extRequestFlag, takenLevel;
    logic [13:0] periphReq;
    logic [3:0] irqIndex, inService, takenIndex, takenCount, ackDelay;
    logic instrBoundary, vectorAck, serviceReturn, irqReq, wakeIdle, wakePowerDown;
    int failures = 0;
    int checks = 0;
    flic_core flic_core_inst (.core_clk(core_clk), .reset_n(reset_n), .spiVariant(spiVariant),
        .irqEnableRegA(irqEnableRegA), .irqEnableRegB(irqEnableRegB), .prioLowRegA(prioLowRegA),
        .prioHighRegA(prioHighRegA), .prioLowRegB(prioLowRegB), .prioHighRegB(prioHighRegB),
        .extIn0TypeSel(extIn0TypeSel), .extIn1TypeSel(extIn1TypeSel), .extIrqPin(extIrqPin),
        .periphReq(periphReq), .instrBoundary(instrBoundary), .vectorAck(vectorAck),
        .serviceReturn(serviceReturn), .irqReq(irqReq), .irqIndex(irqIndex), .irqLevel(irqLevel),
        .extRequestFlag(extRequestFlag), .inService(inService), .wakeIdle(wakeIdle),
        .wakePowerDown(wakePowerDown));
    flic_cpu_model flic_cpu_model_inst (.core_clk(core_clk), .reset_n(reset_n), .irqReq(irqReq),
        .irqIndex(irqIndex), .irqLevel(irqLevel), .ackDelay(ackDelay), .boundaryEn(boundaryEn),
        .retReq(retReq), .instrBoundary(instrBoundary), .vectorAck(vectorAck),
        .serviceReturn(serviceReturn), .takenIndex(takenIndex), .takenLevel(takenLevel),
        .takenCount(takenCount));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic stop_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic lvl(input int s, input logic [1:0] l);
        if (s < 7)
            {prioHighRegA[s], prioLowRegA[s]} = l;
        else
            {prioHighRegB[s-7], prioLowRegB[s-7]} = l;
    endtask
    // wait for the core to take a vector, then drop its request
    task automatic take(input logic [3:0] i, input logic [1:0] l);
        logic [3:0] c0;
        c0 = takenCount;
        for (int k = 0; k < 30 && takenCount === c0; k++)
            tick(1);
        if (takenCount === c0)
        begin
            failures++;
            $display("Error vector expected %h seen none", i);
            stop_test();
        end
        chk("index", i, takenIndex);
        chk("level", {2'h0, l}, {2'h0, takenLevel});
        periphReq[i] = 1'b0;
    endtask
    task automatic noTake(input int n);
        logic [3:0] c0;
        c0 = takenCount;
        tick(n);
        chk("taken", c0, takenCount);
        chk("irqReq", 4'h0, {3'h0, irqReq});
    endtask
    task automatic ret();
        retReq = 1'b1;
        tick(1);
        retReq = 1'b0;
        tick(1);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic tPrio();
        lvl(1, 2'h0); lvl(4, 2'h1); lvl(9, 2'h2); lvl(13, 2'h3);
        periphReq = 14'h2212;
        boundaryEn = 1'b1;
        take(4'hD, 2'h3);
        chk("inService", 4'h8, inService);
        ret();
        take(4'h9, 2'h2);
        ret();
        take(4'h4, 2'h1);
        ret();
        take(4'h1, 2'h0);
        ret();
    endtask
    task automatic tTie();
        ackDelay = 4'h3;
        lvl(5, 2'h1); lvl(11, 2'h1); lvl(12, 2'h2);
        periphReq = 14'h1820;
        take(4'hC, 2'h2);
        ret();
        take(4'h5, 2'h1);
        ret();
        take(4'hB, 2'h1);
        ret();
        ackDelay = 4'h0;
    endtask
    task automatic tNest();
        lvl(9, 2'h1); lvl(3, 2'h1); lvl(7, 2'h2); lvl(6, 2'h3); lvl(8, 2'h3);
        periphReq[9] = 1'b1;
        take(4'h9, 2'h1);
        periphReq[3] = 1'b1;
        noTake(10);
        periphReq[7] = 1'b1;
        take(4'h7, 2'h2);
        chk("inService", 4'h6, inService);
        periphReq[6] = 1'b1;
        take(4'h6, 2'h3);
        periphReq[8] = 1'b1;
        noTake(10);
        ret();
        take(4'h8, 2'h3);
        ret();
        ret();
        noTake(6);
        ret();
        take(4'h3, 2'h1);
        ret();
    endtask
    task automatic tGate();
        irqEnableRegB = 7'h7E;
        periphReq[7] = 1'b1;
        noTake(6);
        chk("wakeIdle", 4'h0, {3'h0, wakeIdle});
        irqEnableRegB = 7'h7F;
        irqEnableRegA = 8'h7F;
        noTake(6);
        chk("wakeIdle", 4'h0, {3'h0, wakeIdle});
        irqEnableRegA = 8'hFF;
        take(4'h7, 2'h2);
        ret();
    endtask
    task automatic tExt();
        boundaryEn = 1'b0;
        extIn0TypeSel = 1'b1;
        lvl(0, 2'h1); lvl(2, 2'h2);
        tick(2);
        extIrqPin = 2'h2;
        tick(4);
        chk("extRequestFlag", 4'h1, {2'h0, extRequestFlag});
        chk("wakePowerDown", 4'h1, {3'h0, wakePowerDown});
        chk("wakeIdle", 4'h1, {3'h0, wakeIdle});
        extIrqPin = 2'h3;
        boundaryEn = 1'b1;
        take(4'h0, 2'h1);
        chk("extRequestFlag", 4'h0, {2'h0, extRequestFlag});
        ret();
        extIrqPin = 2'h1;
        take(4'h2, 2'h2);
        chk("extRequestFlag", 4'h0, {2'h0, extRequestFlag});
        extIrqPin = 2'h3;
        tick(2);
        ret();
        noTake(8);
    endtask
    task automatic tVar();
        spiVariant = 1'b1;
        lvl(10, 2'h1);
        periphReq[10] = 1'b1;
        take(4'hA, 2'h1);
        ret();
        extIrqPin = 2'h1;
        noTake(8);
        extIrqPin = 2'h3;
        tick(1);
        spiVariant = 1'b0;
        periphReq[10] = 1'b1;
        noTake(8);
        periphReq[10] = 1'b0;
        boundaryEn = 1'b0;
        extIn1TypeSel = 1'b1;
        extIrqPin = 2'h1;
        tick(4);
        chk("extRequestFlag", 4'h2, {2'h0, extRequestFlag});
        extIrqPin = 2'h3;
        boundaryEn = 1'b1;
        take(4'h2, 2'h2);
        chk("extRequestFlag", 4'h0, {2'h0, extRequestFlag});
        ret();
    endtask
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial
    begin
        {reset_n, spiVariant, extIn0TypeSel, extIn1TypeSel, boundaryEn, retReq} = 6'h00;
        {irqEnableRegA, irqEnableRegB} = 15'h7FFF;
        {prioLowRegA, prioHighRegA, prioLowRegB, prioHighRegB} = 28'h0;
        extIrqPin = 2'h3;
        periphReq = 14'h0;
        ackDelay = 4'h0;
        tick(3);
        reset_n = 1'b1;
        tick(1);
        tPrio();
        tTie();
        tNest();
        tGate();
        tExt();
        tVar();
        stop_test();
    end
endmodule
`default_nettype wire
